// [rtl/core_slice.sv]
// Purpose: Executes subtract-with-borrow, nibble swap, test-zero-skip, xor and table ops.
// Assumes: Each instruction cycle is four clocks (Q1..Q4); inputs synchronous to ref_clk.
// Notes:   Software registers are writable only while no instruction is running.
//
// Overview of operation
// RULE1: Byte operands come from the access bank when a is 0 and from the selected bank when 1.
// RULE2: With the extension on, a at 0 and f up to 95, f is an offset added to the index register.
// RULE3: Nibble swap exchanges the two halves of the operand and leaves all flags alone.
// RULE4: Table read loads the byte at the table pointer into the latch in two cycles, no flags.
// RULE5: Table read low opcode bits pick keep, post-increment, post-decrement or pre-increment.
// RULE6: Pre-increment bumps the pointer before the access, post variants adjust it after.
// RULE7: The table pointer is 21 bits and addresses single bytes over two megabytes.
// RULE8: Table write copies the latch into the holding byte picked by the pointer's low 3 bits.
// RULE9: Table writes reach only the holding bytes; program memory is changed by other logic.
// RULE10: Table write uses the same four pointer update choices as table read.
// RULE11: Table write takes two cycles, reading the latch and writing the holding byte in Q4.
// RULE12: Test-zero-skip discards the fetched next instruction when the operand is zero.
// RULE13: Skipping a two-word instruction makes the test take three cycles in total.
// RULE14: Literal xor puts W xor the 8-bit literal in W and updates negative and zero.
// RULE15: Subtract with borrow computes f minus W minus not-carry and updates N, OV, C, DC, Z.
// RULE16: Destination bit 0 writes W, 1 writes the file register; register xor updates N and Z.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module core_slice (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Instruction issue
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  output      logic        instr_ready,
  output      logic        instr_done,
  output      logic        discard_next,
  // Data memory
  output      logic [11:0] dmem_addr,
  input  wire logic [7:0]  dmem_rdata,
  output      logic [7:0]  dmem_wdata,
  output      logic        dmem_we,
  // Program memory and holding bytes
  output      logic [20:0] pmem_addr,
  output      logic        pmem_rd,
  input  wire logic [7:0]  pmem_rdata,
  output      logic [63:0] hold_image
);
  core_slice_pkg::phase_t state_reg;
  logic [1:0]  cyc_reg;
  logic [1:0]  ncyc_reg;
  logic [15:0] ir_reg;
  logic        two_reg;
  logic [7:0]  w_reg;
  logic [4:0]  stat_reg;
  logic [3:0]  bsr_reg;
  logic [11:0] fsr2_reg;
  logic        ext_reg;
  logic [20:0] table_pointer_reg;
  logic [7:0]  table_latch_register_reg;
  logic [7:0]  hold_reg [8];
  logic [7:0]  fv_reg;
  logic [7:0]  res_reg;
  logic [4:0]  flag_reg;
  logic [7:0]  tmp_reg;
  logic [2:0]  hidx_reg;
  logic [11:0] dmem_addr_reg;
  logic [20:0] pmem_addr_reg;
  logic [31:0] rdata_reg;
  logic        rd_done_reg;
  logic [20:0] ptr_start_reg;
  logic        accept;
  logic        wr_fire;
  logic        last_q4;
  logic        op_subb;
  logic        op_swap;
  logic        op_tstz;
  logic        op_xorl;
  logic        op_xorf;
  logic        op_table_read_op;
  logic        op_table_write_op;
  logic        op_tbl;
  logic        dest_file;
  logic        indexed;
  logic [1:0]  tmode;
  logic [11:0] addr_next;
  logic [8:0]  diff9;
  logic [4:0]  nib5;
  logic        borrow;

  localparam logic [7:0] RST8 = core_slice_pkg::RST_BYTE;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Decode.
  assign op_subb   = ir_reg[15:10] == core_slice_pkg::OPC_SUBB;
  assign op_swap   = ir_reg[15:10] == core_slice_pkg::OPC_SWAP;
  assign op_tstz   = ir_reg[15:9] == core_slice_pkg::OPC_TSTZ;
  assign op_xorl   = ir_reg[15:8] == core_slice_pkg::OPC_XORL;
  assign op_xorf   = ir_reg[15:10] == core_slice_pkg::OPC_XORF;
  assign op_table_read_op  = ir_reg[15:2] == core_slice_pkg::OPC_TABLE_READ_OP;
  assign op_table_write_op  = ir_reg[15:2] == core_slice_pkg::OPC_TABLE_WRITE_OP;
  assign op_tbl    = op_table_read_op || op_table_write_op;
  assign tmode     = ir_reg[1:0];
  assign dest_file = ir_reg[9] && (op_subb || op_swap || op_xorf); // RULE16
  assign indexed   = ext_reg && !ir_reg[8] && ir_reg[7:0] <= core_slice_pkg::INDEX_LIMIT; // RULE2

  always_comb
  begin
    if (indexed)
      addr_next = 12'(fsr2_reg + {4'h0, ir_reg[7:0]}); // RULE2
    else if (ir_reg[8])
      addr_next = {bsr_reg, ir_reg[7:0]}; // RULE1
    else if (ir_reg[7:0] >= core_slice_pkg::ACCESS_SPLIT)
      addr_next = {core_slice_pkg::SFR_BANK, ir_reg[7:0]}; // RULE1
    else
      addr_next = {4'h0, ir_reg[7:0]}; // RULE1
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing.
  assign instr_ready  = state_reg == core_slice_pkg::ST_IDLE;
  assign accept       = instr_ready && instr_valid;
  assign wr_fire      = avs_write && instr_ready;
  assign last_q4      = state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'(ncyc_reg - 2'h1);
  assign instr_done   = last_q4 && !discard_next; // RULE12 RULE13
  assign discard_next = state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0 && op_tstz
                        && fv_reg == 8'h00; // RULE12

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= core_slice_pkg::ST_IDLE;
      cyc_reg   <= 2'h0;
    end
    else
    begin
      case (state_reg)
        core_slice_pkg::ST_IDLE:
        begin
          cyc_reg <= 2'h0;
          if (instr_valid) state_reg <= core_slice_pkg::ST_Q1;
        end
        core_slice_pkg::ST_Q1: state_reg <= core_slice_pkg::ST_Q2;
        core_slice_pkg::ST_Q2: state_reg <= core_slice_pkg::ST_Q3;
        core_slice_pkg::ST_Q3: state_reg <= core_slice_pkg::ST_Q4;
        default:
        begin
          if (last_q4 && !discard_next) state_reg <= core_slice_pkg::ST_IDLE;
          else
          begin
            state_reg <= core_slice_pkg::ST_Q1;
            cyc_reg   <= 2'(cyc_reg + 2'h1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ir_reg   <= 16'h0000;
      two_reg  <= 1'b0;
      ncyc_reg <= core_slice_pkg::CYC_ONE;
    end
    else if (accept)
    begin
      ir_reg   <= instr_word;
      two_reg  <= next_two_word;
      ncyc_reg <= (instr_word[15:3] == 13'h0001) ? core_slice_pkg::CYC_TWO
                                                  : core_slice_pkg::CYC_ONE; // RULE4 RULE11
    end
    else if (discard_next)
      ncyc_reg <= two_reg ? core_slice_pkg::CYC_THREE : core_slice_pkg::CYC_TWO; // RULE13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch, arithmetic and result.
  assign borrow = ~stat_reg[core_slice_pkg::FLAG_C];
  assign diff9  = 9'({1'b0, fv_reg} - {1'b0, w_reg} - {8'h00, borrow}); // RULE15
  assign nib5   = 5'({1'b0, fv_reg[3:0]} - {1'b0, w_reg[3:0]} - {4'h0, borrow});

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dmem_addr_reg <= 12'h000;
      fv_reg        <= RST8;
      res_reg       <= RST8;
      flag_reg      <= core_slice_pkg::RST_FLAGS;
    end
    else if (cyc_reg == 2'h0)
    begin
      if (state_reg == core_slice_pkg::ST_Q1) dmem_addr_reg <= addr_next;
      if (state_reg == core_slice_pkg::ST_Q2) fv_reg <= dmem_rdata;
      if (state_reg == core_slice_pkg::ST_Q3)
      begin
        flag_reg <= stat_reg; // RULE3
        if (op_subb)
        begin
          res_reg <= diff9[7:0];
          flag_reg[core_slice_pkg::FLAG_C]  <= ~diff9[8]; // RULE15
          flag_reg[core_slice_pkg::FLAG_DC] <= ~nib5[4];
          flag_reg[core_slice_pkg::FLAG_OV] <= (fv_reg[7] != w_reg[7]) && (diff9[7] != fv_reg[7]);
          flag_reg[core_slice_pkg::FLAG_N]  <= diff9[7];
          flag_reg[core_slice_pkg::FLAG_Z]  <= diff9[7:0] == 8'h00;
        end
        else if (op_swap)
          res_reg <= {fv_reg[3:0], fv_reg[7:4]}; // RULE3
        else if (op_xorl || op_xorf)
        begin
          res_reg <= w_reg ^ (op_xorl ? ir_reg[7:0] : fv_reg); // RULE14 RULE16
          flag_reg[core_slice_pkg::FLAG_N] <= w_reg[7] ^ (op_xorl ? ir_reg[7] : fv_reg[7]);
          flag_reg[core_slice_pkg::FLAG_Z] <= (w_reg ^ (op_xorl ? ir_reg[7:0] : fv_reg)) == 8'h00;
        end
      end
    end
  end

  assign dmem_addr  = dmem_addr_reg;
  assign dmem_wdata = res_reg;
  assign dmem_we    = state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0 && dest_file; // RULE16

  ////////////////////////////////////////////////////////////////////////////
  // Table access: pointer, latch and holding bytes.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pmem_addr_reg <= core_slice_pkg::RST_PTR;
      tmp_reg       <= RST8;
      hidx_reg      <= 3'h0;
      ptr_start_reg <= core_slice_pkg::RST_PTR;
    end
    else
    begin
      if (accept) ptr_start_reg <= table_pointer_reg;
      if (op_tbl && cyc_reg == 2'h1 && state_reg == core_slice_pkg::ST_Q1)
        pmem_addr_reg <= table_pointer_reg; // RULE7
      if (op_tbl && cyc_reg == 2'h1 && state_reg == core_slice_pkg::ST_Q2)
      begin
        tmp_reg  <= op_table_read_op ? pmem_rdata : table_latch_register_reg; // RULE4 RULE11
        hidx_reg <= table_pointer_reg[2:0]; // RULE8
      end
    end
  end

  assign pmem_addr = pmem_addr_reg;
  assign pmem_rd   = op_table_read_op && cyc_reg == 2'h1 && state_reg == core_slice_pkg::ST_Q2; // RULE4

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      table_pointer_reg <= core_slice_pkg::RST_PTR;
    else if (wr_fire && avs_address == core_slice_pkg::OFF_TABLE_POINTER)
      table_pointer_reg <= 21'(merge({11'h000, table_pointer_reg}, avs_writedata, avs_byteenable));
    else if (op_tbl && state_reg == core_slice_pkg::ST_Q3)
    begin
      if (cyc_reg == 2'h0 && tmode == core_slice_pkg::TBL_PRE_INC)
        table_pointer_reg <= 21'(table_pointer_reg + 21'h1); // RULE5 RULE6 RULE10
      else if (cyc_reg == 2'h1 && tmode == core_slice_pkg::TBL_POST_INC)
        table_pointer_reg <= 21'(table_pointer_reg + 21'h1); // RULE5 RULE6 RULE10
      else if (cyc_reg == 2'h1 && tmode == core_slice_pkg::TBL_POST_DEC)
        table_pointer_reg <= 21'(table_pointer_reg - 21'h1); // RULE5 RULE6 RULE10
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      table_latch_register_reg <= RST8;
    else if (wr_fire && avs_address == core_slice_pkg::OFF_TBLLAT)
      table_latch_register_reg <= 8'(merge({24'h0, table_latch_register_reg}, avs_writedata, avs_byteenable));
    else if (op_table_read_op && last_q4)
      table_latch_register_reg <= tmp_reg; // RULE4
  end

  // Holding bytes are only written here; flash programming consumes hold_image.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 8; i++) hold_reg[i] <= RST8;
    end
    else if (op_table_write_op && last_q4)
      hold_reg[hidx_reg] <= tmp_reg; // RULE8 RULE9 RULE11
  end

  for (genvar g = 0; g < 8; g++)
  begin : g_hold
    assign hold_image[g*8 +: 8] = hold_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register, flags and configuration.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      w_reg <= RST8;
    else if (wr_fire && avs_address == core_slice_pkg::OFF_WREG)
      w_reg <= 8'(merge({24'h0, w_reg}, avs_writedata, avs_byteenable));
    else if (state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0 && !dest_file
             && (op_subb || op_swap || op_xorf || op_xorl))
      w_reg <= res_reg; // RULE14 RULE16
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stat_reg <= core_slice_pkg::RST_FLAGS;
    else if (wr_fire && avs_address == core_slice_pkg::OFF_STATUS)
      stat_reg <= 5'(merge({27'h0, stat_reg}, avs_writedata, avs_byteenable));
    else if (state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0
             && (op_subb || op_xorf || op_xorl))
      stat_reg <= flag_reg; // RULE14 RULE15 RULE16
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bsr_reg  <= 4'h0;
      fsr2_reg <= core_slice_pkg::RST_INDEX;
      ext_reg  <= core_slice_pkg::RST_EXT;
    end
    else if (wr_fire)
    begin
      if (avs_address == core_slice_pkg::OFF_BANK)
        bsr_reg <= 4'(merge({28'h0, bsr_reg}, avs_writedata, avs_byteenable));
      else if (avs_address == core_slice_pkg::OFF_INDEX)
        fsr2_reg <= 12'(merge({20'h0, fsr2_reg}, avs_writedata, avs_byteenable));
      else if (avs_address == core_slice_pkg::OFF_CTRL && avs_byteenable[0])
        ext_reg <= avs_writedata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path: one wait cycle, data from a flop.
  assign avs_waitrequest = (avs_read && !rd_done_reg) || (avs_write && !instr_ready);
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_reg   <= 32'h0000_0000;
      rd_done_reg <= 1'b0;
    end
    else
    begin
      rd_done_reg <= avs_read && !rd_done_reg;
      if (avs_read && !rd_done_reg)
      begin
        if (avs_address == core_slice_pkg::OFF_CTRL)        rdata_reg <= {31'h0, ext_reg};
        else if (avs_address == core_slice_pkg::OFF_WREG)   rdata_reg <= {24'h0, w_reg};
        else if (avs_address == core_slice_pkg::OFF_STATUS) rdata_reg <= {27'h0, stat_reg};
        else if (avs_address == core_slice_pkg::OFF_BANK)   rdata_reg <= {28'h0, bsr_reg};
        else if (avs_address == core_slice_pkg::OFF_TABLE_POINTER) rdata_reg <= {11'h0, table_pointer_reg};
        else if (avs_address == core_slice_pkg::OFF_TBLLAT) rdata_reg <= {24'h0, table_latch_register_reg};
        else if (avs_address == core_slice_pkg::OFF_INDEX)  rdata_reg <= {20'h0, fsr2_reg};
        else if (avs_address >= core_slice_pkg::OFF_HOLD0
                 && avs_address <= core_slice_pkg::OFF_HOLD7)
          rdata_reg <= {24'h0, hold_reg[avs_address[4:2]]};
        else                                                rdata_reg <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  sequence s_tbl_accept;
    accept && instr_word[15:3] == 13'h0001;
  endsequence

  a_bank_select: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
    state_reg == core_slice_pkg::ST_Q2 && cyc_reg == 2'h0 && ir_reg[8]
    |-> dmem_addr == {bsr_reg, ir_reg[7:0]})
    else $error("banked operand address wrong");
  a_indexed_addr: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
    state_reg == core_slice_pkg::ST_Q2 && cyc_reg == 2'h0 && indexed
    |-> dmem_addr == 12'(fsr2_reg + {4'h0, ir_reg[7:0]}))
    else $error("indexed operand address wrong");
  a_swap_result: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
    dmem_we && op_swap |-> dmem_wdata == {fv_reg[3:0], fv_reg[7:4]}
    ##1 stat_reg == $past(stat_reg))
    else $error("nibble swap wrong or flags changed");
  a_tbl_length: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE4
    s_tbl_accept |-> !instr_done [*8] ##1 instr_done)
    else $error("table op not two instruction cycles");
  a_ptr_update: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
    s_tbl_accept ##8 (tmode == core_slice_pkg::TBL_POST_DEC)
    |-> table_pointer_reg == 21'(ptr_start_reg - 21'h1))
    else $error("post-decrement pointer wrong");
  a_pre_access: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
    pmem_rd |-> pmem_addr == ((tmode == core_slice_pkg::TBL_PRE_INC) ?
                              21'(ptr_start_reg + 21'h1) : ptr_start_reg))
    else $error("table access address wrong");
  a_hold_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
    op_table_write_op && state_reg == core_slice_pkg::ST_Q2 && cyc_reg == 2'h1
    ##2 last_q4 ##1 1'b1 |-> hold_reg[$past(table_pointer_reg[2:0], 4)] == $past(table_latch_register_reg, 4))
    else $error("holding byte not written from latch");
  a_skip_two: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE13
    discard_next && two_reg |-> !instr_done [*8] ##1 instr_done)
    else $error("two-word skip not three cycles");
  a_no_skip: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
    state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0 && op_tstz && fv_reg != 8'h00
    |-> instr_done && !discard_next)
    else $error("nonzero test skipped");
  a_xor_literal: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
    accept && instr_word[15:8] == core_slice_pkg::OPC_XORL
    |-> ##4 ##1 w_reg == ($past(w_reg, 5) ^ $past(instr_word[7:0], 5)))
    else $error("literal xor result wrong");
  a_sub_carry: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE15
    state_reg == core_slice_pkg::ST_Q4 && cyc_reg == 2'h0 && op_subb
    |=> stat_reg[core_slice_pkg::FLAG_C] == ($past(fv_reg) >= 9'($past(w_reg) + $past(borrow))))
    else $error("subtract carry wrong");
endmodule : core_slice

// [rtl/core_slice_pkg.sv]
// Purpose: Shared constants for the instruction-slice execution unit.
// Assumes: Avalon-MM register window with 32-bit data and byte addressing.
// Notes:   Register offsets are byte addresses, one aligned word each.
package core_slice_pkg;
  // Register map (byte offsets).
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_WREG    = 6'h04;
  localparam logic [5:0] OFF_STATUS  = 6'h08;
  localparam logic [5:0] OFF_BANK    = 6'h0C;
  localparam logic [5:0] OFF_TABLE_POINTER  = 6'h10;
  localparam logic [5:0] OFF_TBLLAT  = 6'h14;
  localparam logic [5:0] OFF_INDEX   = 6'h18;
  localparam logic [5:0] OFF_HOLD0   = 6'h20;
  localparam logic [5:0] OFF_HOLD7   = 6'h3C;
  // Status flag positions.
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;
  // Reset values.
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [4:0]  RST_FLAGS  = 5'h00;
  localparam logic [20:0] RST_PTR    = 21'h000000;
  localparam logic [11:0] RST_INDEX  = 12'h000;
  localparam logic        RST_EXT    = 1'b0;
  // Access-bank split and indexed literal offset limit.
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;
  localparam logic [3:0]  SFR_BANK     = 4'hF;
  // Opcode patterns.
  localparam logic [5:0]  OPC_SUBB  = 6'h16;
  localparam logic [5:0]  OPC_SWAP  = 6'h0E;
  localparam logic [6:0]  OPC_TSTZ  = 7'h33;
  localparam logic [7:0]  OPC_XORL  = 8'h0A;
  localparam logic [5:0]  OPC_XORF  = 6'h06;
  localparam logic [13:0] OPC_TABLE_READ_OP = 14'h0002;
  localparam logic [13:0] OPC_TABLE_WRITE_OP = 14'h0003;
  // Table pointer update modes.
  localparam logic [1:0] TBL_KEEP = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC  = 2'h3;
  // Instruction-cycle counts.
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1   = 3'b001,
    ST_Q2   = 3'b010,
    ST_Q3   = 3'b011,
    ST_Q4   = 3'b100
  } phase_t;
endpackage : core_slice_pkg

// [testbench/cpu_table_access_alu_ops_tb_top.sv]
// Purpose: Self-checking bench for the instruction slice unit.
// Assumes: Bench owns register bus, instruction port and data memory.
// Notes:   Latencies are checked against the one-cycle operations.
`timescale 1ns/1ps
module cpu_table_access_alu_ops_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        instr_valid = 1'b0;
  logic        next_two_word = 1'b0;
  logic [15:0] instr_word = 16'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, instr_ready, instr_done, discard_next, dmem_we, pmem_rd;
  logic [11:0] dmem_addr;
  logic [7:0]  dmem_rdata, dmem_wdata, pmem_rdata;
  logic [20:0] pmem_addr;
  logic [63:0] hold_image;
  logic [7:0]  dm [4096];
  logic [31:0] note_q [$];
  int          fail_count = 0;
  int          comparisons = 0;
  int          base = 4;
  core_slice uut (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .instr_valid, .instr_word,
    .next_two_word, .instr_ready, .instr_done, .discard_next, .dmem_addr, .dmem_rdata,
    .dmem_wdata, .dmem_we, .pmem_addr, .pmem_rd, .pmem_rdata, .hold_image);
  pmem_model flash (.pmem_addr, .pmem_rd, .pmem_rdata);
  assign dmem_rdata = dm[dmem_addr];
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Results are matched in order: read data and data memory writes share one queue.
  always @(posedge ref_clk)
  begin
    if (dmem_we === 1'b1)
      dm[dmem_addr] <= dmem_wdata;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, note_q.size() ? note_q.pop_front() : 32'hX);
    if (dmem_we === 1'b1)
      check({12'h0, dmem_addr, dmem_wdata}, note_q.size() ? note_q.pop_front() : 32'hX);
  end
  task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    note_q.push_back(exp);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic exec(input logic [15:0] iw, input logic two, output int n, output logic disc);
    n = 0;
    disc = 1'b0;
    instr_word <= iw;
    next_two_word <= two;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    while (instr_done !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
      disc = disc | (discard_next === 1'b1);
    end
    @(posedge ref_clk);
  endtask : exec
  initial
  begin
    #400000;
    fail_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] fa, fv, w, r;
    logic [4:0] s, es, h;
    logic [11:0] adr, idx;
    logic [20:0] p, pa, pn;
    logic [63:0] hold;
    logic [15:0] iw;
    logic [8:0] t;
    logic [3:0] bk;
    logic [1:0] op;
    logic a, d, x, disc;
    int n;
    hold = 64'h0;
    void'($urandom(32'h00C9));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(core_slice_pkg::OFF_TABLE_POINTER, 32'h0);
    rd(6'h1C, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      op = 2'(i % 4);
      fa = 8'($urandom_range(0, 191));
      fv = 8'($urandom);
      w = (i % 8 < 4) ? fv : 8'($urandom);
      s = 5'($urandom) | ((i % 8 < 4) ? 5'h01 : 5'h00);
      {d, a, x, bk} = 7'($urandom);
      d = d && op != 2'h3;
      idx = 12'($urandom_range(0, 3584));
      adr = a ? {bk, fa} : (x && fa <= 8'h5F) ? idx + 12'(fa) : {(fa < 8'h60) ? 4'h0 : 4'hF, fa};
      dm[adr] = fv;
      t = {1'b0, fv} - {1'b0, w} - {8'h0, !s[0]};
      h = {1'b0, fv[3:0]} - {1'b0, w[3:0]} - {4'h0, !s[0]};
      r = (op == 2'h0) ? t[7:0] : (op == 2'h1) ? {fv[3:0], fv[7:4]} : fv ^ w;
      iw = (op == 2'h0) ? {core_slice_pkg::OPC_SUBB, d, a, fa} : (op == 2'h1) ?
        {core_slice_pkg::OPC_SWAP, d, a, fa} : (op == 2'h2) ?
        {core_slice_pkg::OPC_XORF, d, a, fa} : {core_slice_pkg::OPC_XORL, fv};
      es = (op == 2'h1) ? s : {r[7], (op == 2'h0) ? (fv[7] != w[7] && r[7] != fv[7]) : s[3],
        r == 8'h00, (op == 2'h0) ? {!h[4], !t[8]} : s[1:0]};
      bus(core_slice_pkg::OFF_WREG, 1'b1, {24'h0, w});
      bus(core_slice_pkg::OFF_STATUS, 1'b1, {27'h0, s});
      bus(core_slice_pkg::OFF_CTRL, 1'b1, {31'h0, x});
      bus(core_slice_pkg::OFF_BANK, 1'b1, {28'h0, bk});
      bus(core_slice_pkg::OFF_INDEX, 1'b1, {20'h0, idx});
      if (d)
        note_q.push_back({12'h0, adr, r});
      exec(iw, 1'b0, n, disc);
      check(n, base);
      rd(core_slice_pkg::OFF_WREG, {24'h0, d ? w : r});
      rd(core_slice_pkg::OFF_STATUS, {27'h0, es});
    end
    bus(core_slice_pkg::OFF_CTRL, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      dm[12'h010] = i[0] ? 8'h00 : 8'h5A;
      exec({core_slice_pkg::OPC_TSTZ, 1'b0, 8'h10}, i[1], n, disc);
      check(n - base, i[0] ? (i[1] ? 8 : 4) : 0);
      check(disc, i[0]);
      rd(core_slice_pkg::OFF_STATUS, {27'h0, es});
    end
    for (int i = 0; i < 8; i++)
    begin
      p = (i == 2) ? 21'h0 : (i == 7) ? 21'h1FFFFF : 21'($urandom);
      fv = 8'($urandom);
      pa = (i[1:0] == 2'h3) ? p + 21'h1 : p;
      pn = (i[1:0] == 2'h0) ? p : (i[1:0] == 2'h2) ? p - 21'h1 : p + 21'h1;
      bus(core_slice_pkg::OFF_TABLE_POINTER, 1'b1, {11'h0, p});
      bus(core_slice_pkg::OFF_TBLLAT, 1'b1, {24'h0, fv});
      exec({i[2] ? core_slice_pkg::OPC_TABLE_WRITE_OP : core_slice_pkg::OPC_TABLE_READ_OP, i[1:0]}, 1'b0, n, disc);
      check(n - base, 4);
      if (i[2])
        hold[pa[2:0] * 8 +: 8] = fv;
      check(hold_image, hold);
      rd(core_slice_pkg::OFF_TBLLAT, {24'h0, i[2] ? fv : flash.content(pa)});
      rd(core_slice_pkg::OFF_TABLE_POINTER, {11'h0, pn});
    end
    bus(core_slice_pkg::OFF_HOLD7, 1'b1, 32'hFFFFFFFF);
    rd(core_slice_pkg::OFF_HOLD7, {24'h0, hold[63:56]});
    check(note_q.size(), 0);
    print_verdict();
  end
endmodule : cpu_table_access_alu_ops_tb_top

// [testbench/pmem_model.sv]
// Purpose: Behavioural program flash behind the table read path.
// Assumes: Byte reads only; contents are a fixed function of the address.
// Notes:   Outside a read strobe the data lines show the inverse pattern.
`timescale 1ns/1ps
module pmem_model (
  // Flash read port
  input  wire logic [20:0] pmem_addr,
  input  wire logic        pmem_rd,
  output      logic [7:0]  pmem_rdata
);
  function automatic logic [7:0] content(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {a[20:16], 3'h5};
  endfunction : content
  // There is no write path, so nothing can change the contents.
  assign pmem_rdata = pmem_rd ? content(pmem_addr) : ~content(pmem_addr);
endmodule : pmem_model
